// ### hdl/flash_host_regs.svh
// Constants for the flash command host: register map, status fields, opcodes, timing.
// Assumes a word-wide flash and a 100 MHz sys_clk.
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// Register byte offsets
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0c
`define REG_STATUS 8'h10

// Status fields
`define ST_BUSY 0
`define ST_MODE_LO 1
`define ST_MODE_HI 2
`define ST_SUSP 3
`define ST_REFUSED 4
`define ST_TLIMIT 5
`define ST_READY 6

// Reset values
`define RST_ADDR 20'h0_0000
`define RST_WDATA 16'h0000

// Flash command addresses and data (word mode)
`define FA_UNLOCK1 11'h555
`define FA_UNLOCK2 20'h0_02aa
`define FA_QUERY 20'h0_0055
`define FD_UNLOCK1 16'h00aa
`define FD_UNLOCK2 16'h0055
`define FD_AUTOSEL 16'h0090
`define FD_QUERY 16'h0098
`define FD_RESET 16'h00f0
`define FD_SUSPEND 16'h00b0
`define FD_RESUME 16'h0030
`define FO_MFR 8'h00
`define FO_DEV 8'h01
`define FO_PROT 8'h02
`define TLIMIT_BIT 5

// Timing: strobe width and setup, in ns, and derived cycle counts (rounded up)
`define CLK_PERIOD_NS 10
`define T_STROBE_NS 80
`define T_SETUP_NS 20
`define STROBE_CYC 4'((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC 4'((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### hdl/flash_host_pkg.sv
// Types shared by the flash command host and its bus cycle engine.
// Constants live in flash_host_regs.svh.
package flash_host_pkg;

    typedef enum logic [3:0] {
        CMD_READ = 4'h0,
        CMD_WRITE = 4'h1,
        CMD_RESET = 4'h2,
        CMD_AUTOSEL = 4'h3,
        CMD_QUERY = 4'h4,
        CMD_ID_MFR = 4'h5,
        CMD_ID_DEV = 4'h6,
        CMD_ID_PROT = 4'h7
    } cmd_t;

    typedef enum logic [1:0] {
        MODE_READ = 2'b00,
        MODE_SUSP_READ = 2'b01,
        MODE_AUTOSEL = 2'b10,
        MODE_QUERY = 2'b11
    } mode_t;

    // One flash bus cycle request
    typedef struct packed {
        logic write;
        logic last;
        logic [19:0] addr;
        logic [15:0] data;
    } step_t;

    // Flash pins driven by the host
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [19:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
    } pins_t;

endpackage

// ### hdl/flash_bus_cycle.sv
// One asynchronous flash bus cycle (read or write) per start pulse.
// Assumes dq_in synchronous to sys_clk; all pins come from flops.
`timescale 1ns/1ps
`include "flash_host_regs.svh"

module flash_bus_cycle (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Request
    input wire logic start,
    input wire flash_host_pkg::step_t req,
    output flash_host_pkg::pins_t pins_q,
    output logic done_q,
    output logic [15:0] rdata_q,
    // Data pins in
    input wire logic [15:0] dq_in
);
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SETUP = 2'b01,
        PH_STROBE = 2'b10,
        PH_HOLD = 2'b11
    } phase_t;

    phase_t ph_q, ph_d;
    logic [3:0] cnt_q, cnt_d;
    flash_host_pkg::pins_t pins_d;
    logic done_d;
    logic [15:0] rdata_d;

    always_comb begin
        ph_d = ph_q;
        cnt_d = cnt_q;
        pins_d = pins_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        case (ph_q)
            PH_IDLE: begin
                if (start) begin
                    // Address and data settle while chip select falls, strobe comes later
                    pins_d.ce_n = 1'b0;
                    pins_d.addr = req.addr; // [R1]
                    pins_d.dq_out = req.data;
                    pins_d.dq_oe = req.write;
                    cnt_d = `SETUP_CYC;
                    ph_d = PH_SETUP;
                end
            end
            PH_SETUP: begin
                if (cnt_q <= 4'h1) begin
                    pins_d.we_n = ~pins_q.dq_oe;
                    pins_d.oe_n = pins_q.dq_oe;
                    cnt_d = `STROBE_CYC;
                    ph_d = PH_STROBE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            PH_STROBE: begin
                if (cnt_q <= 4'h1) begin
                    // Write strobe rises first while chip select and data still hold
                    pins_d.we_n = 1'b1; // [R2]
                    pins_d.oe_n = 1'b1;
                    if (!pins_q.dq_oe) begin
                        rdata_d = dq_in;
                    end
                    ph_d = PH_HOLD;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            PH_HOLD: begin
                pins_d.ce_n = 1'b1;
                pins_d.dq_oe = 1'b0;
                done_d = 1'b1;
                ph_d = PH_IDLE;
            end
            default: ph_d = PH_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ph_q <= PH_IDLE;
            cnt_q <= 4'h0;
            pins_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 20'h0_0000, dq_out: 16'h0000, dq_oe: 1'b0};
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (clk_en) begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
        end
    end

    // Data is never driven while the strobe is low on a read, nor dropped before we_n rises
    property p_data_held;
        @(posedge sys_clk) disable iff (!rstn)
        $rose(pins_q.we_n) |-> pins_q.dq_oe && !pins_q.ce_n;
    endproperty
    a_data_held: assert property (p_data_held) else $error("data released before write strobe rose"); // [R2]

    property p_addr_stable;
        @(posedge sys_clk) disable iff (!rstn)
        $fell(pins_q.we_n) |-> $stable(pins_q.addr) && !pins_q.ce_n && $past(!pins_q.ce_n);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address not settled at write strobe fall"); // [R1]

endmodule // flash_bus_cycle

// ### hdl/flash_cmd_host.sv
// Flash command host: turns register orders into flash command sequences and tracks bank mode.
// Assumes a single word-mode flash on the pins and a ready/busy pin synchronous to sys_clk.
//
// What the document requires
// R1: Address must settle before the later falling edge of write strobe or select.
// R2: Data must stay valid through the first rising edge of strobe or select.
// R3: After power-up the flash is taken to be in read-array mode.
// R4: A bank returns to read-array mode when a program or erase ends.
// R5: After erase suspend the bank serves reads from non-suspended sectors.
// R6: Host writes reset when time-limit bit rises during busy, or leaving autoselect.
// R7: Reset command works regardless of address, restoring read or suspended-read mode.
// R8: Reset inside an erase sequence aborts it; ignored once erasing runs.
// R9: Reset inside a program sequence aborts it; ignored once programming runs.
// R10: Reset leaves autoselect to suspended-read if suspended, else to read-array.
// R11: Host issues autoselect only in read modes and never while busy.
// R12: Autoselect is two unlock writes then bank address with the autoselect command.
// R13: In autoselect, repeated reads in the bank return identification data.
// R14: Offset 00 gives manufacturer code, offset 01 gives device code.
// R15: Sector address with offset 02 reads 01 if protected, else 00.
// R16: Host writes only valid command values in the proper order.
// R17: Query offset 27h reads 0016h, device size as a power of two.
// R18: Query offset 2Ch reports two erase regions; regions three, four zero.
// R19: Query 2Dh to 30h describe the first erase region.
// R20: Query 31h to 34h describe the second erase region.
// R21: Query 40h to 44h read P, R, I and version characters.
// R22: Query 46h reads 0002h; 47h and 48h read 0001h.
// R23: Query entry is 98h at word address 55h; reset leaves it.
`timescale 1ns/1ps
`include "flash_host_regs.svh"

module flash_cmd_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    // Flash pins
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic [19:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    input wire logic flash_ready
);
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_ISSUE = 2'b01,
        SQ_WAIT = 2'b10
    } seq_t;

    // Builds each bus cycle of a command; sequences come only from here, in fixed order
    function automatic flash_host_pkg::step_t step_of(input flash_host_pkg::cmd_t c, input logic [1:0] n,
                                                      input logic [19:0] a, input logic [15:0] d);
        flash_host_pkg::step_t s;
        s = '{write: 1'b0, last: 1'b1, addr: a, data: d}; // [R16]
        case (c)
            flash_host_pkg::CMD_WRITE: s.write = 1'b1;
            flash_host_pkg::CMD_RESET: begin
                s.write = 1'b1;
                s.data = `FD_RESET; // [R7]
            end
            flash_host_pkg::CMD_AUTOSEL: begin
                s.write = 1'b1;
                s.last = (n == 2'd2);
                case (n)
                    2'd0: s = '{write: 1'b1, last: 1'b0, addr: {9'h000, `FA_UNLOCK1}, data: `FD_UNLOCK1}; // [R12]
                    2'd1: s = '{write: 1'b1, last: 1'b0, addr: `FA_UNLOCK2, data: `FD_UNLOCK2}; // [R12]
                    default: s = '{write: 1'b1, last: 1'b1, addr: {a[19:11], `FA_UNLOCK1}, data: `FD_AUTOSEL};
                endcase
            end
            flash_host_pkg::CMD_QUERY: s = '{write: 1'b1, last: 1'b1, addr: `FA_QUERY, data: `FD_QUERY}; // [R23]
            flash_host_pkg::CMD_ID_MFR: s.addr = {a[19:8], `FO_MFR}; // [R14]
            flash_host_pkg::CMD_ID_DEV: s.addr = {a[19:8], `FO_DEV}; // [R14]
            flash_host_pkg::CMD_ID_PROT: s.addr = {a[19:8], `FO_PROT}; // [R15]
            default: s.write = 1'b0;
        endcase
        return s;
    endfunction

    seq_t sq_q, sq_d;
    flash_host_pkg::cmd_t cmd_q, cmd_d;
    flash_host_pkg::mode_t mode_q, mode_d;
    logic [1:0] step_q, step_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [15:0] rslt_q, rslt_d;
    logic susp_q, susp_d;
    logic refused_q, refused_d;
    logic tlimit_q, tlimit_d;
    logic busy_at_read_q, busy_at_read_d;
    logic [31:0] rdata_d;
    logic cyc_start;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    flash_host_pkg::step_t cur_step;
    flash_host_pkg::pins_t pins;

    assign cur_step = step_of(cmd_q, step_q, addr_q, wdata_q);
    assign cyc_start = (sq_q == SQ_ISSUE);

    flash_bus_cycle u_cycle (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .start(cyc_start),
        .req(cur_step),
        .pins_q(pins),
        .done_q(cyc_done),
        .rdata_q(cyc_rdata),
        .dq_in(flash_dq_in)
    );

    assign flash_ce_n = pins.ce_n;
    assign flash_we_n = pins.we_n;
    assign flash_oe_n = pins.oe_n;
    assign flash_addr = pins.addr;
    assign flash_dq_out = pins.dq_out;
    assign flash_dq_oe = pins.dq_oe;

    always_comb begin
        sq_d = sq_q;
        cmd_d = cmd_q;
        mode_d = mode_q;
        step_d = step_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rslt_d = rslt_q;
        susp_d = susp_q;
        refused_d = refused_q;
        tlimit_d = tlimit_q;
        busy_at_read_d = busy_at_read_q;
        rdata_d = 32'h0000_0000;
        // Software clears sticky flags; a same-cycle hardware set below wins
        if (reg_wr && reg_addr == `REG_STATUS) begin
            if (reg_wdata[`ST_REFUSED]) refused_d = 1'b0;
            if (reg_wdata[`ST_TLIMIT]) tlimit_d = 1'b0;
        end
        if (reg_wr && reg_addr == `REG_ADDR) addr_d = reg_wdata[19:0];
        if (reg_wr && reg_addr == `REG_WDATA) wdata_d = reg_wdata[15:0];
        case (sq_q)
            SQ_IDLE: begin
                if (reg_wr && reg_addr == `REG_CMD) begin
                    cmd_d = flash_host_pkg::cmd_t'(reg_wdata[3:0]);
                    step_d = 2'd0;
                    busy_at_read_d = !flash_ready;
                    // Autoselect only from a read mode and only with no operation running
                    if (cmd_d == flash_host_pkg::CMD_AUTOSEL && (!flash_ready ||
                        mode_q == flash_host_pkg::MODE_AUTOSEL || mode_q == flash_host_pkg::MODE_QUERY)) begin
                        refused_d = 1'b1; // [R11]
                    end else begin
                        sq_d = SQ_ISSUE;
                    end
                end
            end
            SQ_ISSUE: sq_d = SQ_WAIT;
            SQ_WAIT: begin
                if (cyc_done) begin
                    if (!cur_step.write) rslt_d = cyc_rdata;
                    if (!cur_step.last) begin
                        step_d = step_q + 2'd1;
                        sq_d = SQ_ISSUE;
                    end else begin
                        sq_d = SQ_IDLE;
                        case (cmd_q)
                            flash_host_pkg::CMD_RESET: begin
                                mode_d = susp_q ? flash_host_pkg::MODE_SUSP_READ
                                                : flash_host_pkg::MODE_READ; // [R10] [R7]
                            end
                            flash_host_pkg::CMD_AUTOSEL: mode_d = flash_host_pkg::MODE_AUTOSEL; // [R12]
                            flash_host_pkg::CMD_QUERY: mode_d = flash_host_pkg::MODE_QUERY; // [R23]
                            flash_host_pkg::CMD_WRITE: begin
                                // Suspend and resume are tracked from raw command writes
                                if (wdata_q == `FD_SUSPEND) begin
                                    susp_d = 1'b1;
                                    mode_d = flash_host_pkg::MODE_SUSP_READ; // [R5]
                                end else if (wdata_q == `FD_RESUME) begin
                                    susp_d = 1'b0;
                                    mode_d = flash_host_pkg::MODE_READ;
                                end
                            end
                            flash_host_pkg::CMD_READ: begin
                                // Time limit seen during a busy operation: recover with a reset
                                if (busy_at_read_q && cyc_rdata[`TLIMIT_BIT]) begin
                                    tlimit_d = 1'b1; // [R6]
                                    cmd_d = flash_host_pkg::CMD_RESET;
                                    step_d = 2'd0;
                                    sq_d = SQ_ISSUE;
                                end
                            end
                            default: mode_d = mode_q;
                        endcase
                    end
                end
            end
            default: sq_d = SQ_IDLE;
        endcase
        // A busy device ends its operation back in read-array; ready pin marks it
        if (flash_ready && !susp_q && mode_q == flash_host_pkg::MODE_SUSP_READ) begin
            mode_d = flash_host_pkg::MODE_READ; // [R4]
        end
        if (reg_wr && reg_addr == `REG_CMD && sq_q != SQ_IDLE) refused_d = 1'b1;
        if (reg_rd) begin
            case (reg_addr)
                `REG_ADDR: rdata_d = {12'h000, addr_q};
                `REG_WDATA: rdata_d = {16'h0000, wdata_q};
                `REG_RDATA: rdata_d = {16'h0000, rslt_q};
                `REG_STATUS: rdata_d = {25'h000_0000, flash_ready, tlimit_q, refused_q, susp_q, mode_q,
                                        sq_q != SQ_IDLE};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sq_q <= SQ_IDLE;
            cmd_q <= flash_host_pkg::CMD_READ;
            mode_q <= flash_host_pkg::MODE_READ; // [R3]
            step_q <= 2'd0;
            addr_q <= `RST_ADDR;
            wdata_q <= `RST_WDATA;
            rslt_q <= 16'h0000;
            susp_q <= 1'b0;
            refused_q <= 1'b0;
            tlimit_q <= 1'b0;
            busy_at_read_q <= 1'b0;
            reg_rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            sq_q <= sq_d;
            cmd_q <= cmd_d;
            mode_q <= mode_d;
            step_q <= step_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rslt_q <= rslt_d;
            susp_q <= susp_d;
            refused_q <= refused_d;
            tlimit_q <= tlimit_d;
            busy_at_read_q <= busy_at_read_d;
            reg_rdata_q <= rdata_d;
        end
    end

    property p_power_up_read;
        @(posedge sys_clk) $rose(rstn) |-> mode_q == flash_host_pkg::MODE_READ;
    endproperty
    a_power_up_read: assert property (p_power_up_read) else $error("mode not read-array after reset"); // [R3]

    property p_autosel_refused;
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && sq_q == SQ_IDLE && reg_wr && reg_addr == `REG_CMD && reg_wdata[3:0] == 4'h3
        && (!flash_ready || mode_q == flash_host_pkg::MODE_AUTOSEL || mode_q == flash_host_pkg::MODE_QUERY)
        |=> refused_q && sq_q == SQ_IDLE;
    endproperty
    a_autosel_refused: assert property (p_autosel_refused) else $error("autoselect issued while busy"); // [R11]

    property p_autosel_order;
        @(posedge sys_clk) disable iff (!rstn)
        // Checked on the pins, not on the step builder, so a wrong latch of the step is caught too
        $fell(flash_we_n) && cmd_q == flash_host_pkg::CMD_AUTOSEL && step_q == 2'd2
        |-> flash_dq_out == `FD_AUTOSEL && flash_addr[10:0] == `FA_UNLOCK1 && flash_addr[19:11] == addr_q[19:11];
    endproperty
    a_autosel_order: assert property (p_autosel_order) else $error("autoselect third cycle malformed"); // [R12]

    property p_reset_leaves_autosel;
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && cyc_done && sq_q == SQ_WAIT && cmd_q == flash_host_pkg::CMD_RESET
        |=> mode_q == (susp_q ? flash_host_pkg::MODE_SUSP_READ : flash_host_pkg::MODE_READ);
    endproperty
    a_reset_leaves_autosel: assert property (p_reset_leaves_autosel) else $error("wrong mode after reset"); // [R10]

    property p_reset_data;
        @(posedge sys_clk) disable iff (!rstn)
        $fell(flash_we_n) && cmd_q == flash_host_pkg::CMD_RESET |-> flash_dq_out == `FD_RESET && flash_dq_oe;
    endproperty
    a_reset_data: assert property (p_reset_data) else $error("reset command data wrong"); // [R7]

    property p_query_entry;
        @(posedge sys_clk) disable iff (!rstn)
        $fell(flash_we_n) && cmd_q == flash_host_pkg::CMD_QUERY |-> flash_addr == `FA_QUERY && flash_dq_out == `FD_QUERY;
    endproperty
    a_query_entry: assert property (p_query_entry) else $error("query entry cycle wrong"); // [R23]

    property p_id_addr;
        @(posedge sys_clk) disable iff (!rstn)
        $fell(flash_oe_n) && cmd_q == flash_host_pkg::CMD_ID_PROT |-> flash_addr[7:0] == `FO_PROT;
    endproperty
    a_id_addr: assert property (p_id_addr) else $error("protect read offset wrong"); // [R15]

    property p_tlimit_recover;
        @(posedge sys_clk) disable iff (!rstn)
        clk_en && cyc_done && sq_q == SQ_WAIT && cmd_q == flash_host_pkg::CMD_READ && busy_at_read_q
        && cyc_rdata[`TLIMIT_BIT] |=> tlimit_q && cmd_q == flash_host_pkg::CMD_RESET ##1 sq_q == SQ_WAIT;
    endproperty
    a_tlimit_recover: assert property (p_tlimit_recover) else $error("no reset after time limit"); // [R6]

    c_autosel: cover property (@(posedge sys_clk) mode_q == flash_host_pkg::MODE_AUTOSEL);
    c_query: cover property (@(posedge sys_clk) mode_q == flash_host_pkg::MODE_QUERY);
    c_tlimit: cover property (@(posedge sys_clk) $rose(tlimit_q));

endmodule // flash_cmd_host

// ### tb/flash_dev_model.sv
// Behavioural word-mode flash: command decoder, autoselect and query data.
// Assumes the host keeps strobe and select timing; it has no clock of its own.
`timescale 1ns/1ps
module flash_dev_model #(
    parameter logic [15:0] MFR_CODE = 16'h00c1, // Arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h2b3c, // Arbitrary value
    parameter logic [2:0] PROT_SECT = 3'h5
) (
    // Pins from the host
    input wire logic flash_ce_n,
    input wire logic flash_we_n,
    input wire logic flash_oe_n,
    input wire logic [19:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    // Pins to the host
    output logic [15:0] flash_dq_in
);
    logic [19:0] lat_a = 20'h0_0000;
    logic [15:0] last_q = 16'h0000;
    logic [15:0] rv;
    logic [8:0] bank = 9'h000;
    logic idm = 1'b0;
    logic qry = 1'b0;
    int step = 0;
    always @(negedge flash_we_n) if (!flash_ce_n && flash_oe_n) lat_a = flash_addr;
    always @(negedge flash_ce_n) if (!flash_we_n && flash_oe_n) lat_a = flash_addr;
    always @(posedge flash_we_n) if (!flash_ce_n) decode(flash_dq_out);
    always @(posedge flash_ce_n) if (!flash_we_n) decode(flash_dq_out);
    task automatic decode(input logic [15:0] d);
        if (d[7:0] == 8'hf0) begin
            idm = 1'b0;
            qry = 1'b0;
            step = 0;
        end else if (d == 16'h0098 && lat_a == 20'h0_0055) qry = 1'b1;
        else if (step == 0 && d == 16'h00aa && lat_a[10:0] == 11'h555) step = 1;
        else if (step == 1 && d == 16'h0055 && lat_a[10:0] == 11'h2aa) step = 2;
        else if (step == 2 && d == 16'h0090) begin
            idm = 1'b1;
            bank = lat_a[19:11];
            step = 0;
        end else step = 0;
    endtask
    always @* begin
        rv = flash_addr[15:0] ^ 16'ha5c3;
        if (qry) begin
            case (flash_addr[7:0])
                8'h27: rv = 16'h0016;
                8'h2c, 8'h46: rv = 16'h0002;
                8'h2d: rv = 16'h0007;
                8'h2f: rv = 16'h0020;
                8'h31: rv = 16'h003e;
                8'h34, 8'h47, 8'h48: rv = 16'h0001;
                8'h40: rv = 16'h0050;
                8'h41: rv = 16'h0052;
                8'h42: rv = 16'h0049;
                8'h43: rv = 16'h0031;
                8'h44: rv = 16'h0033;
                default: rv = 16'h0000;
            endcase
        end else if (idm && flash_addr[19:11] == bank) begin
            if (flash_addr[7:0] == 8'h00) rv = MFR_CODE;
            if (flash_addr[7:0] == 8'h01) rv = DEV_CODE;
            if (flash_addr[7:0] == 8'h02) rv = {15'h0000, flash_addr[10:8] == PROT_SECT};
        end
    end
    // A released bus must not keep the last word, so it shows the inverse
    always @(posedge flash_oe_n) last_q = rv;
    assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rv : ~last_q;
endmodule // flash_dev_model

// ### tb/flash_cmd_host_bench.sv
// Self-checking bench for the flash command host with a flash model on its pins.
// Assumes the register map and status fields of flash_host_regs.svh.
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_cmd_host_bench;
    logic sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, flash_ready = 1'b1, clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata_q, r;
    logic flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe;
    logic [19:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in;
    logic [7:0] qa[18] = '{8'h27, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h3c,
        8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h46};
    logic [15:0] qd[18] = '{16'h0016, 16'h0002, 16'h0007, 16'h0000, 16'h0020, 16'h0000, 16'h003e, 16'h0000,
        16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033, 16'h0002};
    int n_fail = 0, comparisons = 0, cyc = 0;
    initial forever #5 sys_clk = ~sys_clk;
    flash_cmd_host dut (.sys_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ready);
    flash_dev_model model (.flash_ce_n, .flash_we_n, .flash_oe_n, .flash_addr, .flash_dq_out, .flash_dq_in);
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata_q;
    endtask
    // Issues one order, waits for the sequencer, then fetches the last read word
    task cmd(input flash_host_pkg::cmd_t c, input logic [19:0] a);
        int i;
        wr(`REG_ADDR, {12'h000, a});
        wr(`REG_CMD, {28'h000_0000, c});
        i = 0;
        do begin
            rd(`REG_STATUS);
            i++;
        end while (r[`ST_BUSY] !== 1'b0 && i < 100);
        chk({31'h0, r[`ST_BUSY]}, 32'h0000_0000);
        rd(`REG_RDATA);
    endtask
    task mode(input logic [1:0] m);
        rd(`REG_STATUS);
        chk({30'h0, r[`ST_MODE_HI:`ST_MODE_LO]}, {30'h0, m});
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        mode(2'd0);
        cmd(flash_host_pkg::CMD_READ, 20'h0_0123);
        chk(r, 32'h0000_a4e0);
        rd(8'h20);
        chk(r, 32'h0000_0000);
        cmd(flash_host_pkg::CMD_AUTOSEL, 20'h1_2800);
        mode(2'd2);
        cmd(flash_host_pkg::CMD_ID_MFR, 20'h1_2800);
        chk(r, 32'h0000_00c1);
        cmd(flash_host_pkg::CMD_ID_DEV, 20'h1_2800);
        chk(r, 32'h0000_2b3c);
        cmd(flash_host_pkg::CMD_ID_PROT, 20'h1_2d00);
        chk(r, 32'h0000_0001);
        cmd(flash_host_pkg::CMD_ID_PROT, 20'h1_2900);
        chk(r, 32'h0000_0000);
        cmd(flash_host_pkg::CMD_READ, 20'h1_2f01);
        chk(r, 32'h0000_2b3c);
        cmd(flash_host_pkg::CMD_AUTOSEL, 20'h1_2800);
        rd(`REG_STATUS);
        chk({31'h0, r[`ST_REFUSED]}, 32'h0000_0001);
        wr(`REG_STATUS, 32'h0000_0010);
        cmd(flash_host_pkg::CMD_RESET, 20'h3_f0a5);
        mode(2'd0);
        cmd(flash_host_pkg::CMD_READ, 20'h1_2801);
        chk(r, 32'h0000_8dc2);
        cmd(flash_host_pkg::CMD_QUERY, 20'h0_0000);
        mode(2'd3);
        for (int i = 0; i < 18; i++) begin
            cmd(flash_host_pkg::CMD_READ, {12'h000, qa[i]});
            chk({16'h0000, r[15:0]}, {16'h0000, qd[i]});
        end
        cmd(flash_host_pkg::CMD_RESET, 20'h0_0000);
        wr(`REG_WDATA, 32'h0000_00b0);
        cmd(flash_host_pkg::CMD_WRITE, 20'h1_2800);
        mode(2'd1);
        cmd(flash_host_pkg::CMD_READ, 20'h1_2804);
        chk(r, 32'h0000_8dc7);
        cmd(flash_host_pkg::CMD_AUTOSEL, 20'h1_2800);
        cmd(flash_host_pkg::CMD_RESET, 20'h1_2800);
        mode(2'd1);
        wr(`REG_WDATA, 32'h0000_0030);
        cmd(flash_host_pkg::CMD_WRITE, 20'h1_2800);
        mode(2'd0);
        // A write while the enable is low must not land
        clk_en <= 1'b0;
        wr(`REG_WDATA, 32'h0000_1234);
        clk_en <= 1'b1;
        rd(`REG_WDATA);
        chk(r, 32'h0000_0030);
        flash_ready <= 1'b0;
        cmd(flash_host_pkg::CMD_READ, 20'h0_0020);
        chk(r, 32'h0000_a5e3);
        cmd(flash_host_pkg::CMD_AUTOSEL, 20'h1_2800);
        rd(`REG_STATUS);
        chk(r, 32'h0000_0030);
        flash_ready <= 1'b1;
        wr(`REG_STATUS, 32'h0000_0030);
        rd(`REG_STATUS);
        chk(r, 32'h0000_0040);
        test_done;
    end
endmodule // flash_cmd_host_bench
